/* bench/sink_consumer.sv */
`timescale 1ns/1ps
module sink_consumer (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Sink user side
   input wire logic edge_i,
   input wire logic link_up_i,
   input wire logic valid_i,
   // Counts
   output logic [15:0] kept_o,
   output logic [15:0] dropped_o
);
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         kept_o <= 16'h0;
         dropped_o <= 16'h0;
      end else if (edge_i && valid_i) begin
         // A word seen while the link is down is never used, whatever its qualifier.
         if (link_up_i) begin
            kept_o <= kept_o + 16'h1;
         end else begin
            dropped_o <= dropped_o + 16'h1;
         end
      end
   end
endmodule : sink_consumer

/* bench/sink_port_asserts.sv */
`timescale 1ns/1ps
module sink_port_asserts
   import sink_port_pkg::*;
#(
   parameter int LANES = 4
) (
   // Inputs
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic core_reset_i,
   input wire logic init_done_i,
   input wire logic rx_valid_i,
   input wire logic rx_first_i,
   input wire logic [LANES*LANE_BITS-1:0] rx_data_i,
   input wire logic [LANES-1:0] crc_err_i,
   // Outputs
   input wire logic rx_take_o,
   input wire logic user_clock_o,
   input wire logic user_reset_o,
   input wire logic interface_clock_o,
   input wire logic interface_reset_o,
   input wire logic link_up_o,
   input wire logic valid_o,
   input wire logic burst_first_word_o,
   input wire logic [LANES*LANE_BITS-1:0] data_o,
   input wire logic [LANES+ERR_FIXED-1:0] error_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence core_hit_s;
      core_reset_i;
   endsequence
   sequence all_reset_s;
      user_reset_o && interface_reset_o && !link_up_o;
   endsequence
   user_clk_a:
      assert property (!user_reset_o && !$past(user_reset_o) |-> $changed(user_clock_o))
         else $error("user clock idle");
   if_clk_a:
      assert property (!interface_reset_o && !$past(interface_reset_o) |->
         $changed(interface_clock_o)) else $error("interface clock idle");
   reset_back_a:
      assert property (core_hit_s |-> ##[1:6] all_reset_s) else $error("reset not back");
   one_mode_a:
      assert property (user_reset_o || interface_reset_o) else $error("both resets low");
   link_gate_a:
      assert property (link_up_o |-> $past(init_done_i)) else $error("early link up");
   word_out_a:
      assert property ($past(rx_take_o) && valid_o |-> $past(rx_valid_i) &&
         data_o == $past(rx_data_i)) else $error("bad word");
   first_out_a:
      assert property ($past(rx_take_o) && burst_first_word_o |-> $past(rx_first_i) && valid_o)
         else $error("bad first marker");
   stand_a:
      assert property (link_up_o && $past(link_up_o) && $changed(data_o) |-> $past(rx_take_o))
         else $error("data moved");
   void_bit_a:
      assert property (!error_o[LANES+ERR_VOID]) else $error("void bit set");
   crc_bits_a:
      assert property ($past(rx_take_o) && link_up_o && $past(link_up_o, 3) |->
         error_o[LANES-1:0] == ($past(crc_err_i) | $past(crc_err_i, 2)))
         else $error("bad crc bits");
   adv_void_a:
      assert property (!interface_reset_o |->
         error_o[LANES+ERR_ECC_UNCORR:LANES+ERR_FIFO] == 3'h0) else $error("void error set");
endmodule : sink_port_asserts
bind stream_sink_port sink_port_asserts #(.LANES(LANES)) i_sink_port_asserts (.*);

/* bench/tb_stream_sink_port.sv */
`timescale 1ns/1ps
module tb_stream_sink_port;
   import sink_port_pkg::*;
   localparam int LANES = 2;
   localparam int DW = LANES * LANE_BITS;
   localparam int EW = LANES + ERR_FIXED;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic core_reset_i = 1'b0;
   logic init_done_i = 1'b1;
   logic rx_valid_i = 1'b0;
   logic rx_first_i = 1'b0;
   logic rx_last_i = 1'b0;
   logic [DW-1:0] rx_data_i = '0;
   logic [SYNC_W-1:0] rx_sync_i = '0;
   logic [LANES-1:0] crc_err_i = '0;
   logic align_loss_i = 1'b0;
   logic fifo_ovf_i = 1'b0;
   logic ecc_corr_i = 1'b0;
   logic ecc_uncorr_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic rx_take_o, user_clock_o, user_reset_o, interface_clock_o, interface_reset_o;
   logic link_up_o, valid_o, burst_first_word_o, burst_last_word_o;
   logic [31:0] reg_rdata_o;
   logic [DW-1:0] data_o;
   logic [SYNC_W-1:0] sync_o;
   logic [EW-1:0] error_o;
   logic [15:0] dropped;
   int seed = 30456;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   ctrl_s mode = CTRL_RESET;
   logic [EW-1:0] ev_prev = '0;
   logic [31:0] rd;
   stream_sink_port #(.LANES(LANES)) i_stream_sink_port (.*);
   sink_consumer i_sink_consumer (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .edge_i(user_clock_o | interface_clock_o), .link_up_i(link_up_o), .valid_i(valid_o),
      .kept_o(), .dropped_o(dropped));
   always #2.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   function automatic logic [EW-1:0] exp_err(input logic [EW-1:0] ev);
      logic [EW-1:0] e;
      e = ev;
      e[LANES+ERR_VOID] = 1'b0;
      e[LANES+ERR_FIFO] = ev[LANES+ERR_FIFO] & !mode.adv_clk;
      if (mode.adv_clk || !mode.ecc_en) begin
         e[LANES+ERR_ECC_UNCORR:LANES+ERR_ECC_CORR] = 2'h0;
      end
      return e;
   endfunction : exp_err
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_sys_i);
      d = reg_rdata_o;
   endtask : reg_rd
   task automatic wait_up(input int lo);
      int n;
      n = 0;
      while (link_up_o !== 1'b1 && n < 80) begin
         @(negedge clk_sys_i);
         n++;
      end
      #1;
      check(DW'(n >= lo && n < 80), DW'(1'b1));
      check(DW'({user_reset_o, interface_reset_o}), DW'({mode.adv_clk, !mode.adv_clk}));
   endtask : wait_up
   task automatic send(input logic v, f, l, input logic [SYNC_W-1:0] s,
         input logic [EW-1:0] ev, input logic ef);
      logic [DW-1:0] d;
      d = {$random(seed), $random(seed), $random(seed), $random(seed)};
      // Look for a cycle without a take away from the edge; the next cycle takes.
      @(negedge clk_sys_i);
      while (rx_take_o !== 1'b0) begin
         @(negedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      rx_valid_i <= v;
      rx_first_i <= f;
      rx_last_i <= l;
      rx_sync_i <= s;
      rx_data_i <= d;
      {ecc_uncorr_i, ecc_corr_i, fifo_ovf_i} <= ev[EW-1:LANES+ERR_FIFO];
      {align_loss_i, crc_err_i} <= ev[LANES:0];
      @(posedge clk_sys_i);
      // The word is taken at this edge; dropping valid keeps it from being taken again.
      rx_valid_i <= 1'b0;
      #1;
      check(DW'({valid_o, burst_last_word_o}), DW'({v, l & v}));
      check(DW'(burst_first_word_o), DW'(mode.burst_mode ? f & v : ef));
      if (v) begin
         check(data_o, d);
         check(DW'(sync_o), DW'(s));
      end
      check(DW'(error_o), DW'(exp_err(ev | ev_prev)));
      ev_prev = ev;
   endtask : send
   task automatic quiet();
      repeat (2) send(1'b0, 1'b0, 1'b0, '0, '0, 1'b0);
   endtask : quiet
   task automatic burst_run(input int n);
      repeat (n) send(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
         SYNC_W'($random(seed)), EW'($random(seed)), 1'b0);
   endtask : burst_run
   task automatic set_mode(input ctrl_s m);
      // Events are flushed first so that no take straddles the change of masking.
      quiet();
      reg_wr(ADDR_CTRL, 32'(m));
      mode = m;
      repeat (2) @(posedge clk_sys_i);
      wait_up(0);
   endtask : set_mode
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      wait_up(RESET_SEQ_CYCLES);
      reg_wr(4'h8, 32'hffffffff);
      reg_rd(ADDR_CTRL, rd);
      check(DW'(rd), DW'(CTRL_RESET));
      reg_rd(4'hc, rd);
      check(DW'(rd), '0);
      burst_run(30);
      send(1'b1, 1'b0, 1'b1, SYNC_W'(LANES), '0, 1'b0);
      reg_rd(ADDR_STATUS, rd);
      check(DW'(rd[STAT_SYNC_BAD]), DW'(1'b1));
      reg_wr(ADDR_STATUS, 32'h4);
      reg_rd(ADDR_STATUS, rd);
      check(DW'(rd[STAT_SYNC_BAD:STAT_LINK_UP]), DW'(3'h1));
      set_mode(3'h6);
      burst_run(10);
      set_mode(3'h7);
      burst_run(10);
      quiet();
      @(posedge clk_sys_i);
      init_done_i <= 1'b0;
      send(1'b1, 1'b0, 1'b0, '0, '0, 1'b0);
      quiet();
      check(DW'({link_up_o, dropped}), DW'(17'h1));
      @(posedge clk_sys_i);
      init_done_i <= 1'b1;
      set_mode(3'h0);
      @(posedge clk_sys_i);
      core_reset_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      core_reset_i <= 1'b0;
      wait_up(RESET_SEQ_CYCLES);
      send(1'b1, 1'b1, 1'b0, '0, '0, 1'b1);
      send(1'b1, 1'b1, 1'b1, '0, '0, 1'b0);
      test_done();
   end
endmodule : tb_stream_sink_port

/* inc/sink_port_pkg.sv */
package sink_port_pkg;

   // Register port map (byte addresses on a 4-bit address).
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;

   // Control word, low bits of ADDR_CTRL.
   typedef struct packed {
      logic ecc_en;
      logic burst_mode;
      logic adv_clk;
   } ctrl_s;

   localparam int CTRL_W = 3;
   localparam ctrl_s CTRL_RESET = 3'h2;

   // Status word field positions in ADDR_STATUS.
   localparam int STAT_LINK_UP = 0;
   localparam int STAT_IN_RESET = 1;
   localparam int STAT_SYNC_BAD = 2;
   localparam int STAT_FIRST_SEEN = 3;

   // Error vector: N lane bits plus this many fixed bits above them.
   localparam int ERR_FIXED = 5;
   localparam int ERR_ALIGN = 0;
   localparam int ERR_VOID = 1;
   localparam int ERR_FIFO = 2;
   localparam int ERR_ECC_CORR = 3;
   localparam int ERR_ECC_UNCORR = 4;

   localparam int LANE_BITS = 64;
   localparam int SYNC_W = 8;

   // Reset sequence: least time after the master reset is released.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RESET_SEQ_NS = 100;
   localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SEQ_CNT_W = 8;

   typedef enum logic [1:0] {
      RST_HOLD = 2'b00,
      RST_WAIT = 2'b01,
      RST_RUN = 2'b11
   } rst_state_e;

endpackage : sink_port_pkg

/* src/stream_sink_port.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module stream_sink_port
   import sink_port_pkg::*;
#(
   parameter int LANES = 4
) (
   // Clock and module reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Asynchronous master reset from outside
   input wire logic core_reset_i,
   // Receive core side
   input wire logic init_done_i,
   input wire logic rx_valid_i,
   input wire logic [LANES*LANE_BITS-1:0] rx_data_i,
   input wire logic [SYNC_W-1:0] rx_sync_i,
   input wire logic rx_first_i,
   input wire logic rx_last_i,
   input wire logic [LANES-1:0] crc_err_i,
   input wire logic align_loss_i,
   input wire logic fifo_ovf_i,
   input wire logic ecc_corr_i,
   input wire logic ecc_uncorr_i,
   output logic rx_take_o,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // User side
   output logic user_clock_o,
   output logic user_reset_o,
   output logic interface_clock_o,
   output logic interface_reset_o,
   output logic link_up_o,
   output logic [LANES*LANE_BITS-1:0] data_o,
   output logic [SYNC_W-1:0] sync_o,
   output logic valid_o,
   output logic burst_first_word_o,
   output logic burst_last_word_o,
   output logic [LANES+ERR_FIXED-1:0] error_o
);

   if (LANES < 1 || LANES > 2 ** SYNC_W - 1) begin : g_bad_lanes
      $error("stream_sink_port: LANES out of range");
   end

   // The wait counter must reach the last count of the reset sequence.
   if (RESET_SEQ_CYCLES < 1 || RESET_SEQ_CYCLES > 2 ** SEQ_CNT_W) begin : g_bad_seq
      $error("stream_sink_port: reset sequence does not fit its counter");
   end

   localparam int ERR_W = LANES + ERR_FIXED;
   localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = SEQ_CNT_W'(RESET_SEQ_CYCLES - 1);
   localparam logic [SYNC_W-1:0] SYNC_LIMIT = SYNC_W'(LANES);

   typedef struct packed {
      logic cr_meta;
      logic cr_sync;
      rst_state_e seq;
      logic [SEQ_CNT_W-1:0] seq_cnt;
      logic phase;
      logic take;
      ctrl_s ctrl;
      logic sync_bad;
      logic first_seen;
      logic [ERR_W-1:0] err_acc;
      logic [31:0] rdata;
      logic user_clk;
      logic user_rst;
      logic if_clk;
      logic if_rst;
      logic link_up;
      logic [LANES*LANE_BITS-1:0] data;
      logic [SYNC_W-1:0] sync;
      logic valid;
      logic first;
      logic last;
      logic [ERR_W-1:0] err;
   } state_s;

   state_s s_reg;
   state_s s_next;
   logic [ERR_W-1:0] err_event;
   logic [ERR_W-1:0] err_mask;

   // Per-lane CRC failures occupy the low bits of the event vector.
   for (genvar i = 0; i < LANES; i++) begin : g_lane_err
      assign err_event[i] = crc_err_i[i];
      assign err_mask[i] = 1'b1;
   end
   assign err_event[LANES+ERR_ALIGN] = align_loss_i;
   assign err_event[LANES+ERR_VOID] = 1'b0;
   assign err_event[LANES+ERR_FIFO] = fifo_ovf_i;
   assign err_event[LANES+ERR_ECC_CORR] = ecc_corr_i;
   assign err_event[LANES+ERR_ECC_UNCORR] = ecc_uncorr_i;

   // Bits that mean nothing in the present configuration are forced low.
   assign err_mask[LANES+ERR_ALIGN] = 1'b1;
   assign err_mask[LANES+ERR_VOID] = 1'b0;
   assign err_mask[LANES+ERR_FIFO] = ~s_reg.ctrl.adv_clk;
   assign err_mask[LANES+ERR_ECC_CORR] = s_reg.ctrl.ecc_en & ~s_reg.ctrl.adv_clk;
   assign err_mask[LANES+ERR_ECC_UNCORR] = s_reg.ctrl.ecc_en & ~s_reg.ctrl.adv_clk;

   always_comb begin
      logic running;
      logic word_in;
      logic [31:0] status;
      running = 1'b0;
      word_in = 1'b0;
      status = 32'h0;
      s_next = s_reg;

      // The master reset is asynchronous to this clock, so it is brought in
      // through two flops before the reset sequence looks at it.
      s_next.cr_meta = core_reset_i;
      s_next.cr_sync = s_reg.cr_meta;

      case (s_reg.seq)
         RST_HOLD: begin
            s_next.seq_cnt = '0;
            if (!s_reg.cr_sync) begin
               s_next.seq = RST_WAIT;
            end
         end
         RST_WAIT: begin
            s_next.seq_cnt = s_reg.seq_cnt + 1'b1;
            if (s_reg.cr_sync) begin
               s_next.seq = RST_HOLD;
            end else if (s_reg.seq_cnt == SEQ_LAST) begin
               s_next.seq = RST_RUN;
            end
         end
         RST_RUN: begin
            if (s_reg.cr_sync) begin
               s_next.seq = RST_HOLD;
            end
         end
         default: begin
            s_next.seq = RST_HOLD;
         end
      endcase
      running = (s_reg.seq == RST_RUN);

      // The interface clock is half the system rate. A word is taken when
      // the phase is high, so the outputs change on the falling edge of the
      // outgoing clock and stand a full cycle before its rising edge.
      s_next.phase = ~s_reg.phase;
      s_next.take = ~s_reg.phase;
      s_next.user_clk = ~s_reg.phase & ~s_reg.ctrl.adv_clk;
      s_next.if_clk = ~s_reg.phase & s_reg.ctrl.adv_clk;

      // Only the reset of the selected clock is released; the other stays
      // asserted so logic on the idle clock remains parked.
      s_next.user_rst = ~running | s_reg.ctrl.adv_clk;
      s_next.if_rst = ~running | ~s_reg.ctrl.adv_clk;
      s_next.link_up = running & init_done_i;

      // Events between two takes are gathered so none is lost to the slower
      // output clock; an event on the take cycle goes out with that word.
      s_next.err_acc = s_reg.err_acc | err_event;
      word_in = s_reg.take & rx_valid_i & running;
      if (s_reg.take) begin
         s_next.err_acc = '0;
         s_next.err = (s_reg.err_acc | err_event) & err_mask;
         s_next.valid = word_in;
         s_next.first = 1'b0;
         s_next.last = 1'b0;
         if (word_in) begin
            s_next.data = rx_data_i;
            s_next.sync = rx_sync_i;
            s_next.last = rx_last_i;
            if (s_reg.ctrl.burst_mode) begin
               s_next.first = rx_first_i;
            end else begin
               s_next.first = rx_first_i & ~s_reg.first_seen;
            end
            if (rx_first_i) begin
               s_next.first_seen = 1'b1;
            end
            // An burst_last_word count can name at most LANES-1 unused words,
            // which for one lane means zero.
            if (rx_last_i && rx_sync_i >= SYNC_LIMIT) begin
               s_next.sync_bad = 1'b1;
            end
         end
      end
      if (!running) begin
         s_next.first_seen = 1'b0;
         s_next.valid = 1'b0;
         s_next.first = 1'b0;
         s_next.last = 1'b0;
         s_next.err = '0;
         s_next.err_acc = '0;
      end

      status[STAT_LINK_UP] = s_reg.link_up;
      status[STAT_IN_RESET] = ~running;
      status[STAT_SYNC_BAD] = s_reg.sync_bad;
      status[STAT_FIRST_SEEN] = s_reg.first_seen;

      if (reg_wr_i) begin
         if (reg_addr_i == ADDR_CTRL) begin
            s_next.ctrl = reg_wdata_i[CTRL_W-1:0];
         end else if (reg_addr_i == ADDR_STATUS && reg_wdata_i[STAT_SYNC_BAD]) begin
            // A fault seen in the same cycle as the clear stays recorded.
            s_next.sync_bad = word_in & rx_last_i & (rx_sync_i >= SYNC_LIMIT);
         end
      end

      s_next.rdata = 32'h0;
      if (reg_rd_i) begin
         if (reg_addr_i == ADDR_CTRL) begin
            s_next.rdata = {{(32 - CTRL_W){1'b0}}, s_reg.ctrl};
         end else if (reg_addr_i == ADDR_STATUS) begin
            s_next.rdata = status;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.cr_meta <= 1'b1;
         s_reg.cr_sync <= 1'b1;
         s_reg.seq <= RST_HOLD;
         s_reg.ctrl <= CTRL_RESET;
         s_reg.user_rst <= 1'b1;
         s_reg.if_rst <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rx_take_o = s_reg.take;
   assign reg_rdata_o = s_reg.rdata;
   assign user_clock_o = s_reg.user_clk;
   assign user_reset_o = s_reg.user_rst;
   assign interface_clock_o = s_reg.if_clk;
   assign interface_reset_o = s_reg.if_rst;
   assign link_up_o = s_reg.link_up;
   assign data_o = s_reg.data;
   assign sync_o = s_reg.sync;
   assign valid_o = s_reg.valid;
   assign burst_first_word_o = s_reg.first;
   assign burst_last_word_o = s_reg.last;
   assign error_o = s_reg.err;

endmodule : stream_sink_port
